// ==== rtl/ers_pkg.sv ====
// Purpose: Shared constants for the E1 receive sync status register bank.
// Assumes: 50 MHz reference clock, 8-bit register port.
// Notes:   Offsets are register indices on the plain register port.
package ers_pkg;
  localparam logic [4:0] ERS_SYNC_STATUS_OFS   = 5'h10;
  localparam logic [4:0] ERS_FAS_CAPTURE_OFS   = 5'h11;
  localparam logic [4:0] ERS_TIMER_STATUS_OFS  = 5'h12;
  localparam logic [4:0] ERS_NFAS_CAPTURE_OFS  = 5'h13;
  localparam logic [7:0] ERS_READ_UNMAPPED     = 8'h00;
  localparam logic [7:0] ERS_FAS_RESET         = 8'h00;
  localparam logic [7:0] ERS_NFAS_RESET        = 8'h00;
  localparam int         ERS_CLK_KHZ           = 50000;
  localparam int         ERS_MS_CYCLES         = ERS_CLK_KHZ;
  localparam int         ERS_CRC_SEARCH_MS     = 8;
  localparam int         ERS_CRC_LONG_MS       = 400;
  localparam int         ERS_RED_MS            = 100;
  localparam int         ERS_T1_MS             = 100;
  localparam int         ERS_T2_MS             = 10;
  localparam int         ERS_KEEPALIVE_MS      = 100;
  localparam int         ERS_HALF_SEC_MS       = 500;
  localparam int         ERS_SYNC_BIT          = 7;
  localparam int         ERS_SIGNALLING_MULTIFRAME_LOSS_BIT        = 6;
  localparam int         ERS_CRC_MULTIFRAME_LOSS_BIT        = 5;
  localparam int         ERS_EBIT1_BIT         = 4;
  localparam int         ERS_EBIT2_BIT         = 3;
  localparam int         ERS_CRC_SEARCH_TIMEOUT_BIT         = 2;
  localparam int         ERS_RED_BIT           = 1;
  localparam int         ERS_IWK_BIT           = 0;
endpackage

// ==== rtl/ers_status_bank.sv ====
// Purpose: Read-only sync, alignment capture and timer status words of an E1 receiver.
// Assumes: Framer status inputs are synchronous to ref_clk_i; strobes are one cycle.
// Notes:   Millisecond timers derive from a 1 ms tick on ref_clk_i that restarts at each aligned multiframe start.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Operation
// - Bit 7: frame alignment lost flag.
// - Bit 6: signalling multiframe lost flag.
// - Bit 5: CRC-4 multiframe lost flag.
// - Bits 4,3: last multiframe E bits.
// - Bit 2: CRC-4 not found in 8 ms.
// - Timeout forces reframe under maintenance, no interworking.
// - Bit 1: frame lost 100 ms alarm.
// - Bit 0: CRC-4 interworking status.
// - FAS capture bit 7: received bit one.
// - FAS capture bits 6-0: pattern bits.
// - Half and one second synchronous toggles.
// - Bit 5: non-normal frames persist 100 ms.
// - Bit 4: terminal sync persists 10 ms.
// - Bit 3 toggles on 400 ms expiry.
// - Bit 2 toggles on 8 ms expiry.
// - Bit 1 ms toggle, aligned to multiframe.
// - Bit 0: all-ones alarm held 100 ms.
// - NFAS capture bit 7: received bit one.
// - NFAS capture bit 6: marker bit.
// - NFAS capture bit 5: remote alarm.
// - NFAS capture bits 4-0: national spares.
module ers_status_bank #(
  parameter int MS_CYCLES = ers_pkg::ERS_MS_CYCLES
) (
  input  wire logic       ref_clk_i,                // 50 MHz clock
  input  wire logic       reset_n_i,                // Async reset, active low
  input  wire logic [4:0] reg_addr_i,               // Register index
  input  wire logic [7:0] reg_wdata_i,              // Write data, ignored
  input  wire logic       reg_wr_i,                 // Write strobe, ignored
  input  wire logic       reg_rd_i,                 // Read strobe
  output logic      [7:0] reg_rdata_o,              // Read data, cycle after strobe
  input  wire logic       frame_align_loss_i,       // Basic frame alignment lost
  input  wire logic       signalling_multiframe_loss_i, // Signalling multiframe lost
  input  wire logic       crc_multiframe_loss_i,    // CRC-4 multiframe lost
  input  wire logic       crc_multiframe_sync_i,    // Pulse at CRC-4 multiframe start
  input  wire logic       rx_ebit_first_i,          // E1 bit of this multiframe
  input  wire logic       rx_ebit_second_i,         // E2 bit of this multiframe
  input  wire logic       crc_interworking_i,       // 1 = CRC-to-CRC
  input  wire logic       maintenance_en_i,         // Maintenance option selected
  input  wire logic       auto_interwork_en_i,      // Automatic CRC-4 interworking
  input  wire logic       nonnormal_frames_i,       // Non-normal frames being received
  input  wire logic       terminal_sync_i,          // Terminal frame sync held
  input  wire logic       all_ones_alarm_i,         // All-ones alarm status
  input  wire logic       fas_valid_i,              // Pulse: FAS byte received
  input  wire logic       nfas_valid_i,             // Pulse: NFAS byte received
  input  wire logic [7:0] rx_ts0_byte_i,            // Received time slot 0 byte
  output logic            force_reframe_o,          // Pulse: restart frame search
  output logic            crc_search_timeout_o      // CRC-4 reframe flag
);
  import ers_pkg::*;

  // The limits are fixed, so a prescaler shorter than two cycles is the misuse.
  if (MS_CYCLES < 2) begin : g_ms_cycles_check
    $error("MS_CYCLES must be at least 2");
  end

  localparam int MSW = $clog2(MS_CYCLES);
  // Nine bits hold the longest limit, 400 ms, and its saturated value.
  localparam int CW  = 9;

  if (ERS_CRC_LONG_MS >= (1 << CW)) begin : g_cw_check
    $error("CW too narrow for the longest timer");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and timers.
  // One prescaler feeds every timer, so all limits share one phase.
  // A flag may therefore rise up to one millisecond early or late.
  logic [MSW-1:0] ms_cnt_reg;
  logic [MSW-1:0] ms_cnt_next;
  logic           ms_tick;

  // Free-running toggles.
  logic [8:0]     half_cnt_reg;
  logic [8:0]     half_cnt_next;
  logic           half_second_toggle_reg;
  logic           half_second_toggle_next;
  logic           one_second_toggle_reg;
  logic           one_second_toggle_next;
  logic           crc_ms_toggle_reg;
  logic           crc_ms_toggle_next;

  // Persistence counters, in milliseconds, each saturating at its limit.
  logic [CW-1:0]  red_cnt_reg;
  logic [CW-1:0]  red_cnt_next;
  logic [CW-1:0]  t1_cnt_reg;
  logic [CW-1:0]  t1_cnt_next;
  logic [CW-1:0]  t2_cnt_reg;
  logic [CW-1:0]  t2_cnt_next;
  logic [CW-1:0]  ka_cnt_reg;
  logic [CW-1:0]  ka_cnt_next;
  logic [CW-1:0]  search_cnt_reg;
  logic [CW-1:0]  search_cnt_next;
  logic [CW-1:0]  long_cnt_reg;
  logic [CW-1:0]  long_cnt_next;

  // Status flags read back through the two status words.
  logic           long_frame_loss_alarm_reg;
  logic           long_frame_loss_alarm_next;
  logic           nonnormal_persist_flag_reg;
  logic           nonnormal_persist_flag_next;
  logic           terminal_sync_persist_flag_reg;
  logic           terminal_sync_persist_flag_next;
  logic           keepalive_flag_reg;
  logic           keepalive_flag_next;
  logic           crc_search_timeout_reg;
  logic           crc_search_timeout_next;

  // CRC-4 timer toggles and the reframe request.
  // The request is only a pulse; the framer owns the actual search restart.
  logic           crc_long_timer_toggle_reg;
  logic           crc_long_timer_toggle_next;
  logic           crc_short_timer_toggle_reg;
  logic           crc_short_timer_toggle_next;
  logic           force_reframe_reg;
  logic           force_reframe_next;

  // Saturating persistence counter: counts milliseconds while the condition holds.
  // A single cycle without the condition clears it, so any break restarts the wait.
  function automatic logic [CW-1:0] persist(input logic cond, input logic tick,
                                           input logic [CW-1:0] cnt, input int lim);
    if (!cond) begin
      persist = '0;
    end else if (tick && cnt < CW'(lim)) begin
      persist = cnt + CW'(1);
    end else begin
      persist = cnt;
    end
  endfunction

  // The tick is one clock wide and marks the last cycle of each millisecond.
  assign ms_tick = (ms_cnt_reg == MSW'(MS_CYCLES - 1));

  always_comb begin
    ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + MSW'(1);
    // Once CRC-4 aligned, the ms phase restarts at each multiframe start.
    if (!crc_multiframe_loss_i && crc_multiframe_sync_i) begin
      ms_cnt_next = '0;
    end
    half_cnt_next           = half_cnt_reg;
    half_second_toggle_next = half_second_toggle_reg;
    one_second_toggle_next  = one_second_toggle_reg;
    crc_ms_toggle_next      = crc_ms_toggle_reg;
    // Every millisecond timer advances only on the tick.
    if (ms_tick) begin
      crc_ms_toggle_next = ~crc_ms_toggle_reg;
      if (half_cnt_reg == 9'(ERS_HALF_SEC_MS - 1)) begin
        half_cnt_next           = '0;
        // Both toggles share one counter so they stay in step.
        half_second_toggle_next = ~half_second_toggle_reg;
        if (half_second_toggle_reg) begin
          one_second_toggle_next = ~one_second_toggle_reg;
        end
      end else begin
        half_cnt_next = half_cnt_reg + 9'(1);
      end
    end

    // The alarm follows its counter's registered value, so it rises one cycle after
    // the limit and falls in the cycle after alignment returns.
    red_cnt_next = persist(frame_align_loss_i, ms_tick, red_cnt_reg, ERS_RED_MS);
    long_frame_loss_alarm_next = frame_align_loss_i && (red_cnt_reg >= CW'(ERS_RED_MS));

    // Non-normal frames hold the terminal timer at zero and drop its flag at once.
    // The rising terminal flag in turn clears the non-normal flag, so the two
    // flags are never high together.
    t2_cnt_next = persist(terminal_sync_i && !nonnormal_frames_i, ms_tick, t2_cnt_reg,
                          ERS_T2_MS);
    terminal_sync_persist_flag_next = !nonnormal_frames_i &&
                                      (t2_cnt_reg >= CW'(ERS_T2_MS));
    t1_cnt_next = persist(nonnormal_frames_i, ms_tick, t1_cnt_reg, ERS_T1_MS);
    // The non-normal flag holds between its two events, like a set-reset latch.
    nonnormal_persist_flag_next = nonnormal_persist_flag_reg;
    if (terminal_sync_persist_flag_next) begin
      nonnormal_persist_flag_next = 1'b0;
    end else if (t1_cnt_reg >= CW'(ERS_T1_MS)) begin
      nonnormal_persist_flag_next = 1'b1;
    end

    // Keep-alive drops in the cycle after the all-ones alarm goes away.
    ka_cnt_next = persist(all_ones_alarm_i, ms_tick, ka_cnt_reg, ERS_KEEPALIVE_MS);
    keepalive_flag_next = all_ones_alarm_i && (ka_cnt_reg >= CW'(ERS_KEEPALIVE_MS));

    // The 8 ms search starts when basic frame sync is found.
    search_cnt_next = persist(!frame_align_loss_i && crc_multiframe_loss_i, ms_tick,
                              search_cnt_reg, ERS_CRC_SEARCH_MS);
    crc_short_timer_toggle_next = crc_short_timer_toggle_reg;
    force_reframe_next          = 1'b0;
    crc_search_timeout_next     = crc_search_timeout_reg;
    // The reframe flag stands until CRC-4 alignment is found or basic alignment
    // is lost again. A clear and an expiry need opposite conditions, so they never
    // fall in the same cycle and a flag is never lost to a clear.
    if (!crc_multiframe_loss_i || frame_align_loss_i) begin
      crc_search_timeout_next = 1'b0;
    end
    if (ms_tick && search_cnt_reg == CW'(ERS_CRC_SEARCH_MS - 1) &&
        !frame_align_loss_i && crc_multiframe_loss_i) begin
      crc_search_timeout_next     = 1'b1;
      crc_short_timer_toggle_next = ~crc_short_timer_toggle_reg;
      force_reframe_next          = maintenance_en_i && !auto_interwork_en_i;
    end
    // The 400 ms timer runs whenever CRC-4 multiframe alignment is missing.
    long_cnt_next = persist(crc_multiframe_loss_i, ms_tick, long_cnt_reg, ERS_CRC_LONG_MS);
    crc_long_timer_toggle_next = crc_long_timer_toggle_reg;
    if (ms_tick && crc_multiframe_loss_i && long_cnt_reg == CW'(ERS_CRC_LONG_MS - 1)) begin
      crc_long_timer_toggle_next = ~crc_long_timer_toggle_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_cnt_reg                     <= '0;
      half_cnt_reg                   <= '0;
      half_second_toggle_reg         <= 1'b0;
      one_second_toggle_reg          <= 1'b0;
      crc_ms_toggle_reg              <= 1'b0;
      red_cnt_reg                    <= '0;
      t1_cnt_reg                     <= '0;
      t2_cnt_reg                     <= '0;
      ka_cnt_reg                     <= '0;
      search_cnt_reg                 <= '0;
      long_cnt_reg                   <= '0;
      long_frame_loss_alarm_reg      <= 1'b0;
      nonnormal_persist_flag_reg     <= 1'b0;
      terminal_sync_persist_flag_reg <= 1'b0;
      keepalive_flag_reg             <= 1'b0;
      crc_search_timeout_reg         <= 1'b0;
      crc_long_timer_toggle_reg      <= 1'b0;
      crc_short_timer_toggle_reg     <= 1'b0;
      force_reframe_reg              <= 1'b0;
    end else begin
      ms_cnt_reg                     <= ms_cnt_next;
      half_cnt_reg                   <= half_cnt_next;
      half_second_toggle_reg         <= half_second_toggle_next;
      one_second_toggle_reg          <= one_second_toggle_next;
      crc_ms_toggle_reg              <= crc_ms_toggle_next;
      red_cnt_reg                    <= red_cnt_next;
      t1_cnt_reg                     <= t1_cnt_next;
      t2_cnt_reg                     <= t2_cnt_next;
      ka_cnt_reg                     <= ka_cnt_next;
      search_cnt_reg                 <= search_cnt_next;
      long_cnt_reg                   <= long_cnt_next;
      long_frame_loss_alarm_reg      <= long_frame_loss_alarm_next;
      nonnormal_persist_flag_reg     <= nonnormal_persist_flag_next;
      terminal_sync_persist_flag_reg <= terminal_sync_persist_flag_next;
      keepalive_flag_reg             <= keepalive_flag_next;
      crc_search_timeout_reg         <= crc_search_timeout_next;
      crc_long_timer_toggle_reg      <= crc_long_timer_toggle_next;
      crc_short_timer_toggle_reg     <= crc_short_timer_toggle_next;
      force_reframe_reg              <= force_reframe_next;
    end
  end

  // Both outputs come straight from flip-flops.
  assign force_reframe_o      = force_reframe_reg;
  assign crc_search_timeout_o = crc_search_timeout_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Captures of time slot 0 and of the E bits.
  // The framer delivers whole bytes, so the words are copied without reordering.
  logic [7:0] fas_capture_reg;
  logic [7:0] fas_capture_next;
  logic [7:0] nfas_capture_reg;
  logic [7:0] nfas_capture_next;
  logic [1:0] ebit_reg;
  logic [1:0] ebit_next;

  always_comb begin
    // FAS: bit one in 7, pattern bits two to eight in 6..0.
    fas_capture_next  = fas_valid_i ? rx_ts0_byte_i : fas_capture_reg;
    // NFAS: bit one, marker, remote alarm, national spares.
    nfas_capture_next = nfas_valid_i ? rx_ts0_byte_i : nfas_capture_reg;
    // E bits are sampled at each multiframe start, aligned or not.
    ebit_next         = crc_multiframe_sync_i ? {rx_ebit_first_i, rx_ebit_second_i}
                                              : ebit_reg;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fas_capture_reg  <= ERS_FAS_RESET;
      nfas_capture_reg <= ERS_NFAS_RESET;
      ebit_reg         <= 2'h0;
    end else begin
      fas_capture_reg  <= fas_capture_next;
      nfas_capture_reg <= nfas_capture_next;
      ebit_reg         <= ebit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port. Writes have no effect and reads change no state.
  logic [7:0] sync_word;
  logic [7:0] timer_word;
  // Read data return to zero without a strobe, so a stale word never looks fresh.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    sync_word                 = 8'h00;
    sync_word[ERS_SYNC_BIT]   = frame_align_loss_i;
    sync_word[ERS_SIGNALLING_MULTIFRAME_LOSS_BIT] = signalling_multiframe_loss_i;
    sync_word[ERS_CRC_MULTIFRAME_LOSS_BIT] = crc_multiframe_loss_i;
    sync_word[ERS_EBIT1_BIT]  = ebit_reg[1];
    sync_word[ERS_EBIT2_BIT]  = ebit_reg[0];
    sync_word[ERS_CRC_SEARCH_TIMEOUT_BIT]  = crc_search_timeout_reg;
    sync_word[ERS_RED_BIT]    = long_frame_loss_alarm_reg;
    sync_word[ERS_IWK_BIT]    = crc_interworking_i;
    timer_word = {half_second_toggle_reg, one_second_toggle_reg,
                  nonnormal_persist_flag_reg, terminal_sync_persist_flag_reg,
                  crc_long_timer_toggle_reg, crc_short_timer_toggle_reg,
                  crc_ms_toggle_reg, keepalive_flag_reg};
    // Every index outside the four words reads as zero.
    rdata_next = ERS_READ_UNMAPPED;
    if (!reg_rd_i) begin
      rdata_next = ERS_READ_UNMAPPED;
    end else if (reg_addr_i == ERS_SYNC_STATUS_OFS) begin
      rdata_next = sync_word;
    end else if (reg_addr_i == ERS_FAS_CAPTURE_OFS) begin
      rdata_next = fas_capture_reg;
    end else if (reg_addr_i == ERS_TIMER_STATUS_OFS) begin
      rdata_next = timer_word;
    end else if (reg_addr_i == ERS_NFAS_CAPTURE_OFS) begin
      rdata_next = nfas_capture_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // No wait state: the data stand exactly one cycle after the strobe.
  assign reg_rdata_o = rdata_reg;
endmodule

// ==== sim/ers_status_bank_sva.sv ====
// Purpose: Concurrent checks on the status bank read port and reframe output.
// Assumes: One clock domain; read data stand only in the cycle after the strobe.
// Notes:   Millisecond limits are left to the bench, these hold cycle relations.
`timescale 1ns/1ps
module ers_status_bank_sva
  import ers_pkg::*;
(
  input wire logic       ref_clk_i,                    // Clock
  input wire logic       reset_n_i,                    // Reset, active low
  input wire logic [4:0] reg_addr_i,                   // Register index
  input wire logic       reg_rd_i,                     // Read strobe
  input wire logic [7:0] reg_rdata_o,                  // Read data
  input wire logic       frame_align_loss_i,           // Frame lost
  input wire logic       signalling_multiframe_loss_i, // Multiframe lost
  input wire logic       crc_multiframe_loss_i,        // CRC-4 multiframe lost
  input wire logic       crc_interworking_i,           // Interworking
  input wire logic       maintenance_en_i,             // Maintenance option
  input wire logic       auto_interwork_en_i,          // Auto interworking
  input wire logic       force_reframe_o               // Reframe pulse
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_sync;
    reg_rd_i && reg_addr_i == ERS_SYNC_STATUS_OFS;
  endsequence
  property p_frame_loss;
    s_rd_sync |=> reg_rdata_o[7] == $past(frame_align_loss_i);
  endproperty
  a_frame_loss: assert property (p_frame_loss) else $error("sync bit 7 wrong");
  property p_sig_mf;
    s_rd_sync |=> reg_rdata_o[6] == $past(signalling_multiframe_loss_i);
  endproperty
  a_sig_mf: assert property (p_sig_mf) else $error("sync bit 6 wrong");
  property p_crc_mf;
    s_rd_sync |=> reg_rdata_o[5] == $past(crc_multiframe_loss_i);
  endproperty
  a_crc_mf: assert property (p_crc_mf) else $error("sync bit 5 wrong");
  property p_iwk;
    s_rd_sync |=> reg_rdata_o[0] == $past(crc_interworking_i);
  endproperty
  a_iwk: assert property (p_iwk) else $error("sync bit 0 wrong");
  property p_idle;
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without strobe");
  property p_unmapped;
    reg_rd_i && (reg_addr_i < ERS_SYNC_STATUS_OFS || reg_addr_i > ERS_NFAS_CAPTURE_OFS)
      |=> reg_rdata_o == ERS_READ_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reframe;
    force_reframe_o |-> $past(maintenance_en_i && !auto_interwork_en_i) ##1 !force_reframe_o;
  endproperty
  a_reframe: assert property (p_reframe) else $error("reframe pulse wrong");
  property p_red_clear;
    (!frame_align_loss_i)[*3] ##0 s_rd_sync |=> !reg_rdata_o[1];
  endproperty
  a_red_clear: assert property (p_red_clear) else $error("red alarm stuck");
  c_red: cover property (s_rd_sync ##1 reg_rdata_o[1]);
  c_reframe: cover property (force_reframe_o);
  c_loss: cover property (s_rd_sync ##1 reg_rdata_o[7]);
endmodule
bind ers_status_bank ers_status_bank_sva u_sva (.ref_clk_i, .reset_n_i, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o, .frame_align_loss_i, .signalling_multiframe_loss_i,
  .crc_multiframe_loss_i, .crc_interworking_i, .maintenance_en_i, .auto_interwork_en_i,
  .force_reframe_o);

// ==== sim/ers_status_bank_tb.sv ====
// Purpose: Self-checking bench for the E1 receive sync status bank.
// Assumes: MS_CYCLES is shortened to 20 clocks and every limit scales with it.
// Notes:   Timer limits are sampled 2 to 4 ms either side to absorb tick phase.
`timescale 1ns/1ps
module ers_status_bank_tb;
  import ers_pkg::*;
  localparam int MS = 20;
  localparam logic [4:0] SY = ERS_SYNC_STATUS_OFS, FA = ERS_FAS_CAPTURE_OFS;
  localparam logic [4:0] TM = ERS_TIMER_STATUS_OFS, NF = ERS_NFAS_CAPTURE_OFS;
  logic       ref_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [7:0] wdat = 8'h00, ts0 = 8'h00, rdat, last;
  logic [3:0] pat;
  logic       wr = 1'b0, rdq = 1'b0, fal = 1'b0, sml = 1'b0, cml = 1'b0, mfs = 1'b0;
  logic       eb1 = 1'b0, eb2 = 1'b0, iwk = 1'b0, mnt = 1'b0, aie = 1'b0, nnf = 1'b0;
  logic       tsy = 1'b0, aoa = 1'b0, fv = 1'b0, nv = 1'b0, frf, cst;
  int         cyc = 0, t0 = 0, n_rf = 0, n_mismatch = 0, checks_done = 0;
  ers_status_bank #(.MS_CYCLES(MS)) dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(adr), .reg_wdata_i(wdat),
    .reg_wr_i(wr), .reg_rd_i(rdq), .reg_rdata_o(rdat), .frame_align_loss_i(fal),
    .signalling_multiframe_loss_i(sml), .crc_multiframe_loss_i(cml),
    .crc_multiframe_sync_i(mfs), .rx_ebit_first_i(eb1), .rx_ebit_second_i(eb2),
    .crc_interworking_i(iwk), .maintenance_en_i(mnt), .auto_interwork_en_i(aie),
    .nonnormal_frames_i(nnf), .terminal_sync_i(tsy), .all_ones_alarm_i(aoa),
    .fas_valid_i(fv), .nfas_valid_i(nv), .rx_ts0_byte_i(ts0), .force_reframe_o(frf),
    .crc_search_timeout_o(cst));
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  always @(posedge ref_clk_i) if (frf) n_rf++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The data are taken 1 ns after the edge, since they stand for one cycle only.
  task automatic rd(input logic [4:0] a, input logic [7:0] m, exp, input string what);
    adr <= a;
    rdq <= 1'b1;
    @(posedge ref_clk_i);
    rdq <= 1'b0;
    #1 last = rdat;
    @(posedge ref_clk_i);
    chk(what, last & m, exp);
  endtask
  task automatic cap(input logic nfas, input logic [7:0] b);
    ts0 <= b;
    fv <= !nfas;
    nv <= nfas;
    @(posedge ref_clk_i);
    fv <= 1'b0;
    nv <= 1'b0;
  endtask
  task automatic at_ms(input int m);
    while (cyc - t0 < m * MS) @(posedge ref_clk_i);
  endtask
  task automatic do_reset;
    {fal, sml, cml, iwk, mnt, aie, nnf, tsy, aoa} <= 9'h000;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t0 = cyc;
    n_rf = 0;
    @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_mismatch++;
    close_out();
  end
  initial begin
    do_reset();
    rd(SY, 8'hFF, 8'h00, "sync reset");
    rd(FA, 8'hFF, ERS_FAS_RESET, "fas reset");
    rd(TM, 8'hFF, 8'h00, "timer reset");
    rd(NF, 8'hFF, ERS_NFAS_RESET, "nfas reset");
    for (int i = 0; i < 5; i++) begin
      pat = 4'b1000 >> i;
      {fal, sml, cml, iwk} <= pat;
      @(posedge ref_clk_i);
      rd(SY, 8'hE1, {pat[3:1], 4'h0, pat[0]}, "live bits");
    end
    for (int i = 0; i < 4; i++) begin
      eb1 <= i[1];
      eb2 <= i[0];
      mfs <= 1'b1;
      @(posedge ref_clk_i);
      mfs <= 1'b0;
      @(posedge ref_clk_i);
      rd(SY, 8'h18, {3'h0, i[1], i[0], 3'h0}, "ebits");
    end
    cap(1'b0, 8'h9B);
    rd(FA, 8'hFF, 8'h9B, "fas byte");
    cap(1'b1, 8'h75);
    rd(NF, 8'hFF, 8'h75, "nfas byte");
    rd(FA, 8'hFF, 8'h9B, "fas kept");
    cap(1'b0, 8'h1B);
    cap(1'b1, 8'h4A);
    wdat <= 8'hFF;
    wr <= 1'b1;
    for (int a = 16; a < 20; a++) begin
      adr <= 5'(a);
      @(posedge ref_clk_i);
    end
    wr <= 1'b0;
    rd(FA, 8'hFF, 8'h1B, "fas after write");
    rd(NF, 8'hFF, 8'h4A, "nfas after write");
    rd(SY, 8'hFF, 8'h18, "sync after write");
    rd(5'h1F, 8'hFF, ERS_READ_UNMAPPED, "unmapped high");
    rd(5'h00, 8'hFF, ERS_READ_UNMAPPED, "unmapped low");
    $display("test words and captures done");
    do_reset();
    cml <= 1'b1;
    mnt <= 1'b1;
    aie <= 1'b1;
    at_ms(6);
    rd(SY, 8'h04, 8'h00, "timeout early");
    rd(TM, 8'h04, 8'h00, "short toggle early");
    at_ms(11);
    rd(SY, 8'h04, 8'h04, "timeout");
    rd(TM, 8'h04, 8'h04, "short toggle");
    chk("timeout pin", {7'h00, cst}, 8'h01);
    chk("reframe blocked", 8'(n_rf), 8'h00);
    do_reset();
    cml <= 1'b1;
    mnt <= 1'b1;
    at_ms(11);
    chk("reframe count", 8'(n_rf), 8'h01);
    $display("test crc search timeout done");
    do_reset();
    {fal, cml, aoa, nnf} <= 4'hF;
    at_ms(98);
    rd(SY, 8'h02, 8'h00, "red early");
    rd(TM, 8'h21, 8'h00, "persist early");
    at_ms(102);
    rd(SY, 8'h02, 8'h02, "red");
    rd(TM, 8'h21, 8'h21, "persist");
    {fal, aoa, nnf, tsy} <= 4'h1;
    repeat (4) @(posedge ref_clk_i);
    rd(SY, 8'h02, 8'h00, "red cleared");
    rd(TM, 8'h01, 8'h00, "keepalive cleared");
    at_ms(108);
    rd(TM, 8'h10, 8'h00, "terminal early");
    at_ms(115);
    rd(TM, 8'h30, 8'h10, "terminal sync");
    nnf <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(TM, 8'h10, 8'h00, "terminal dropped");
    at_ms(200);
    repeat (MS / 2) @(posedge ref_clk_i);
    rd(TM, 8'h10, 8'h00, "ms sample");
    repeat (MS - 2) @(posedge ref_clk_i);
    rd(TM, 8'h02, ~last & 8'h02, "ms toggle");
    at_ms(398);
    rd(TM, 8'h08, 8'h00, "long toggle early");
    at_ms(402);
    rd(TM, 8'h08, 8'h08, "long toggle");
    at_ms(498);
    rd(TM, 8'hC0, 8'h00, "second toggles early");
    at_ms(502);
    rd(TM, 8'hC0, 8'h80, "half second");
    at_ms(998);
    rd(TM, 8'hC0, 8'h80, "one second early");
    at_ms(1002);
    rd(TM, 8'hC0, 8'h40, "one second");
    $display("test timers done");
    close_out();
  end
endmodule
